// [hdl/rtc_core.sv]
`timescale 1ns/1ns
`default_nettype none

module rtc_core
   import rtc_pkg::*;
(
   input  wire logic              CLK_SYS,
   input  wire logic              RESET,
   input  wire logic              RC_OSC_CLK,
   input  wire logic              XTAL_OSC_CLK,
   input  wire logic              SLEEP_STATIC,
   input  wire logic              SLEEP_DEEPEST_STOP,
   input  wire logic              DEBUG_HALT,
   input  wire logic              ON_CHIP_DEBUG_RUN,
   input  wire logic              CTRL_WRITE,
   input  wire logic              CTRL_ENABLE,
   input  wire logic              CTRL_PRESCALER_CLEAR,
   input  wire logic              CTRL_DIRECT_WAKE_ENABLE,
   input  wire logic              CTRL_CRYSTAL_OSC_SELECT,
   input  wire logic [PSEL_W-1:0] CTRL_PSEL,
   input  wire logic              TOP_WRITE,
   input  wire logic [CNT_W-1:0]  TOP_WDATA,
   input  wire logic              COUNT_WRITE,
   input  wire logic [CNT_W-1:0]  COUNT_WDATA,
   input  wire logic              IRQ_ENABLE_SET,
   input  wire logic              IRQ_ENABLE_CLEAR,
   input  wire logic              IRQ_STATUS_CLEAR,
   output logic                   ENABLE_VIEW,
   output logic                   PRESCALER_CLEAR_VIEW,
   output logic                   DIRECT_WAKE_ENABLE_VIEW,
   output logic                   CRYSTAL_OSC_SELECT_VIEW,
   output logic [PSEL_W-1:0]      PSEL_VIEW,
   output logic                   BUSY,
   output logic [CNT_W-1:0]       TOP_VIEW,
   output logic [CNT_W-1:0]       COUNT_VALUE,
   output logic                   IRQ_MASK_VIEW,
   output logic                   IRQ_STATUS_VIEW,
   output logic                   IRQ_REQUEST,
   output logic                   IRQ_WAKE,
   output logic                   DIRECT_WAKE
);

   typedef struct packed {
      // live control
      logic              enable;
      logic              wake_en;
      logic              osc_sel;
      logic [PSEL_W-1:0] psel;
      logic [CNT_W-1:0]  top;
      logic [CNT_W-1:0]  cnt;
      // staged writes
      rtc_hs_t           hs;
      logic              busy;
      logic              pend_ctrl;
      logic              pend_top;
      logic              pend_cnt;
      logic              st_enable;
      logic              st_prescaler_clear;
      logic              st_wake_en;
      logic              st_osc_sel;
      logic [PSEL_W-1:0] st_psel;
      logic [CNT_W-1:0]  st_top;
      logic [CNT_W-1:0]  st_cnt;
      // status and outputs
      logic              flag;
      logic              mask;
      logic              wake;
      logic [CNT_W-1:0]  cnt_view;
      logic              irq;
      logic              irq_wake;
      logic              dwake;
   } rtc_core_state_t;

   rtc_core_state_t s_q;
   rtc_core_state_t s_d;

   logic rc_rise;
   logic xt_rise;
   logic pre_tick;
   logic osc_edge;
   logic apply;
   logic pre_clear;
   logic pre_run;
   logic any_write;
   logic wrap;
   logic pending;

   // -------------------------------------------------
   // oscillator pins into the system clock
   // -------------------------------------------------
   rtc_sync u_rc_sync (
      .clk  (CLK_SYS),
      .rst  (RESET),
      .pin  (RC_OSC_CLK),
      .rise (rc_rise)
   );

   rtc_sync u_xt_sync (
      .clk  (CLK_SYS),
      .rst  (RESET),
      .pin  (XTAL_OSC_CLK),
      .rise (xt_rise)
   );

   // -------------------------------------------------
   // prescaler feed
   // -------------------------------------------------
   always_comb begin
      osc_edge  = s_q.osc_sel ? xt_rise : rc_rise;
      // staged update lands on an edge of the counter clock
      apply     = (s_q.hs == RTC_HS_WAIT) & osc_edge;
      pre_clear = apply & s_q.pend_ctrl & s_q.st_prescaler_clear;
      pre_run   = s_q.enable & osc_edge & ~SLEEP_STATIC
                & ~(DEBUG_HALT & ~ON_CHIP_DEBUG_RUN);
   end

   rtc_presc u_presc (
      .clk   (CLK_SYS),
      .rst   (RESET),
      .clear (pre_clear),
      .inc   (pre_run),
      .psel  (s_q.psel),
      .tick  (pre_tick)
   );

   // -------------------------------------------------
   // next state
   // -------------------------------------------------
   always_comb begin
      s_d       = s_q;
      any_write = CTRL_WRITE | TOP_WRITE | COUNT_WRITE;
      wrap      = 1'b0;
      pending   = 1'b0;

      // write crossing handshake
      case (s_q.hs)
         RTC_HS_IDLE: begin
            // writes only taken while not busy
            if (any_write) begin
               s_d.hs        = RTC_HS_WAIT;
               s_d.pend_ctrl = CTRL_WRITE;
               s_d.pend_top  = TOP_WRITE;
               s_d.pend_cnt  = COUNT_WRITE;
               if (CTRL_WRITE) begin
                  s_d.st_enable  = CTRL_ENABLE;
                  s_d.st_prescaler_clear    = CTRL_PRESCALER_CLEAR;
                  s_d.st_wake_en = CTRL_DIRECT_WAKE_ENABLE;
                  s_d.st_osc_sel = CTRL_CRYSTAL_OSC_SELECT;
                  s_d.st_psel    = CTRL_PSEL;
               end
               if (TOP_WRITE) begin
                  s_d.st_top = TOP_WDATA;
               end
               if (COUNT_WRITE) begin
                  s_d.st_cnt = COUNT_WDATA;
               end
            end
         end
         RTC_HS_WAIT: begin
            if (apply) begin
               s_d.hs = RTC_HS_ACK;
            end
         end
         RTC_HS_ACK: begin
            s_d.hs = RTC_HS_IDLE;
         end
         default: begin
            s_d.hs = RTC_HS_IDLE;
         end
      endcase

      // counter
      if (pre_tick) begin
         if (s_q.cnt == s_q.top) begin
            s_d.cnt = CNT_RESET;
            wrap    = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + 32'h00000001;
         end
      end

      // staged values take effect
      if (apply) begin
         if (s_q.pend_ctrl) begin
            s_d.enable  = s_q.st_enable;
            s_d.wake_en = s_q.st_wake_en;
            s_d.osc_sel = s_q.st_osc_sel;
            s_d.psel    = s_q.st_psel;
         end
         if (s_q.pend_top) begin
            s_d.top = s_q.st_top;
         end
         if (s_q.pend_cnt) begin
            s_d.cnt = s_q.st_cnt;
         end
      end

      pending  = s_d.hs != RTC_HS_IDLE;
      s_d.busy = pending;

      // wrap flag, a new wrap beats a clear
      s_d.flag = wrap | (s_q.flag & ~IRQ_STATUS_CLEAR);
      s_d.mask = IRQ_ENABLE_SET
               | (s_q.mask & ~IRQ_ENABLE_CLEAR);

      // direct wake held until wake enable goes low
      s_d.wake = (wrap & s_q.wake_en)
               | (s_q.wake & s_d.wake_en);

      // bus-side copy of the count
      s_d.cnt_view = s_q.cnt;

      s_d.irq      = s_d.mask & s_d.flag
                   & ~SLEEP_DEEPEST_STOP;
      s_d.irq_wake = s_d.irq & ~SLEEP_STATIC;
      s_d.dwake    = s_d.wake & ~SLEEP_STATIC;
   end

   // -------------------------------------------------
   // state register
   // -------------------------------------------------
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         s_q      <= '0;
         s_q.hs   <= RTC_HS_IDLE;
         s_q.psel <= PSEL_RESET;
         s_q.top  <= TOP_RESET;
         s_q.cnt  <= CNT_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // -------------------------------------------------
   // outputs
   // -------------------------------------------------
   assign ENABLE_VIEW             = s_q.enable;
   assign PRESCALER_CLEAR_VIEW    = 1'b0;
   assign DIRECT_WAKE_ENABLE_VIEW = s_q.wake_en;
   assign CRYSTAL_OSC_SELECT_VIEW = s_q.osc_sel;
   assign PSEL_VIEW               = s_q.psel;
   assign BUSY                    = s_q.busy;
   assign TOP_VIEW                = s_q.top;
   assign COUNT_VALUE             = s_q.cnt_view;
   assign IRQ_MASK_VIEW           = s_q.mask;
   assign IRQ_STATUS_VIEW         = s_q.flag;
   assign IRQ_REQUEST             = s_q.irq;
   assign IRQ_WAKE                = s_q.irq_wake;
   assign DIRECT_WAKE             = s_q.dwake;

endmodule : rtc_core

`default_nettype wire

// [hdl/rtc_pkg.sv]
// Notes on behaviour
// - enable starts prescaler on oscillator edges
// - prescaler hidden; clear bit zeroes it
// - select bit picks prescaler input oscillator
// - tap select divides by two^(sel+1)
// - count up to top, then wrap zero
// - wrap from top sets wrap flag
// - top plus one ticks per period
// - count readable; write loads new count
// - synchronised count readout lags count by one cycle
// - mask set, cleared and readable
// - interrupt when mask and flag set
// - status clear drops flag and interrupt
// - interrupt wake except deepest stop, static
// - wake enable plus flag gives direct wake
// - direct wake except static; independent of mask
// - busy while crossing; writes then discarded
// - debug halt freezes prescaler unless kept running
// - runs except static; no interrupt deepest stop
// - prescaler clear reads zero; zero ignored
// - select one crystal, zero RC oscillator
`default_nettype none
package rtc_pkg;

   localparam int CNT_W  = 32;
   localparam int PRE_W  = 16;
   localparam int PSEL_W = 4;

   localparam logic [CNT_W-1:0]  TOP_RESET  = 32'hffffffff;
   localparam logic [CNT_W-1:0]  CNT_RESET  = 32'h00000000;
   localparam logic [PSEL_W-1:0] PSEL_RESET = 4'h0;
   localparam logic [PRE_W-1:0]  PRE_RESET  = 16'h0000;
   localparam logic [PRE_W-1:0]  PRE_ONE    = 16'h0001;

   // write crossing handshake, gray along idle -> wait -> ack
   typedef enum logic [1:0] {
      RTC_HS_IDLE = 2'h0,
      RTC_HS_WAIT = 2'h1,
      RTC_HS_ACK  = 2'h3
   } rtc_hs_t;

   // ones on all prescaler bits below the selected tap
   function automatic logic [PRE_W-1:0] rtc_tap_mask(
      input logic [PSEL_W-1:0] sel);
      rtc_tap_mask = (PRE_ONE << sel) - PRE_ONE;
   endfunction : rtc_tap_mask

endpackage : rtc_pkg

`default_nettype wire

// [hdl/rtc_sync.sv]
`timescale 1ns/1ns
`default_nettype none

module rtc_sync (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic pin,
   output logic      rise
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic rise;
   } rtc_sync_state_t;

   rtc_sync_state_t s_q;
   rtc_sync_state_t s_d;

   // -------------------------------------------------
   // two-flop synchroniser, edge seen after second flop
   // -------------------------------------------------
   always_comb begin
      s_d      = s_q;
      s_d.s1   = pin;
      s_d.s2   = s_q.s1;
      s_d.s3   = s_q.s2;
      s_d.rise = s_q.s2 & ~s_q.s3;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rise = s_q.rise;

endmodule : rtc_sync

`default_nettype wire

// [hdl/rtc_presc.sv]
`timescale 1ns/1ns
`default_nettype none

module rtc_presc
   import rtc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              clear,
   input  wire logic              inc,
   input  wire logic [PSEL_W-1:0] psel,
   output logic                   tick
);

   typedef struct packed {
      logic [PRE_W-1:0] pre;
      logic             tick;
   } rtc_presc_state_t;

   rtc_presc_state_t s_q;
   rtc_presc_state_t s_d;
   logic [PRE_W-1:0] mask;

   // -------------------------------------------------
   // prescaler, tick when selected tap rises
   // -------------------------------------------------
   always_comb begin
      s_d      = s_q;
      mask     = rtc_tap_mask(psel);
      s_d.tick = 1'b0;
      if (clear) begin
         s_d.pre = PRE_RESET;
      end else if (inc) begin
         s_d.pre  = s_q.pre + PRE_ONE;
         // tap bit goes 0->1 every 2^(psel+1) edges
         s_d.tick = ~s_q.pre[psel] & ((s_q.pre & mask) == mask);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;

endmodule : rtc_presc

`default_nettype wire

// [sim/rtc_core_properties.sv]
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------
// crossing, interrupt and wake properties
// ---------------------------------------
module rtc_properties
   import rtc_pkg::*;
(
   input wire logic             CLK_SYS,
   input wire logic             RESET,
   input wire logic             SLEEP_STATIC,
   input wire logic             SLEEP_DEEPEST_STOP,
   input wire logic             CTRL_WRITE,
   input wire logic             TOP_WRITE,
   input wire logic             COUNT_WRITE,
   input wire logic             IRQ_ENABLE_SET,
   input wire logic             IRQ_ENABLE_CLEAR,
   input wire logic             DIRECT_WAKE_ENABLE_VIEW,
   input wire logic             BUSY,
   input wire logic [CNT_W-1:0] TOP_VIEW,
   input wire logic [CNT_W-1:0] COUNT_VALUE,
   input wire logic             IRQ_MASK_VIEW,
   input wire logic             IRQ_STATUS_VIEW,
   input wire logic             IRQ_REQUEST,
   input wire logic             IRQ_WAKE,
   input wire logic             DIRECT_WAKE
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RESET);

   AST_BUSY_RISE: assert property (
      (CTRL_WRITE || TOP_WRITE || COUNT_WRITE) && !BUSY |=> BUSY)
      else $error("accepted write without busy");
   AST_VIEW_HOLD: assert property (
      !BUSY && $past(!BUSY) |-> $stable(TOP_VIEW))
      else $error("top changed outside a crossing");
   AST_COUNT_STEP: assert property (
      !BUSY && !$past(BUSY) && $changed(COUNT_VALUE) && COUNT_VALUE != 0
      |-> COUNT_VALUE == $past(COUNT_VALUE) + 32'h1)
      else $error("count did not step by one");
   AST_WRAP_ZERO: assert property (
      $rose(IRQ_STATUS_VIEW) |=> COUNT_VALUE == 32'h0)
      else $error("wrap flag without count at zero");
   AST_MASK_SET: assert property (
      IRQ_ENABLE_SET |=> IRQ_MASK_VIEW)
      else $error("mask not set");
   AST_MASK_CLR: assert property (
      IRQ_ENABLE_CLEAR && !IRQ_ENABLE_SET |=> !IRQ_MASK_VIEW)
      else $error("mask not cleared");
   AST_IRQ_CAUSE: assert property (
      IRQ_REQUEST |-> IRQ_MASK_VIEW && IRQ_STATUS_VIEW)
      else $error("request without mask and flag");
   AST_IRQ_DEEP: assert property (
      SLEEP_DEEPEST_STOP |=> !IRQ_REQUEST && !IRQ_WAKE)
      else $error("request in deepest stop");
   AST_STATIC: assert property (
      SLEEP_STATIC |=> !IRQ_WAKE && !DIRECT_WAKE)
      else $error("wake in static sleep");
   AST_WAKE: assert property (
      $rose(IRQ_STATUS_VIEW) && DIRECT_WAKE_ENABLE_VIEW && !SLEEP_STATIC
      |-> ##[1:2] DIRECT_WAKE)
      else $error("no direct wake on wrap");

   cover property ($rose(IRQ_REQUEST));
   cover property ($rose(DIRECT_WAKE));
   cover property (BUSY && COUNT_WRITE);
endmodule : rtc_properties

bind rtc_core rtc_properties i_props (.*);
`default_nettype wire

// [sim/real_time_counter_test.sv]
`timescale 1ns/1ns
`default_nettype none
module real_time_counter_test
   import rtc_pkg::*;
();
   logic CLK_SYS, RESET, RC_OSC_CLK, XTAL_OSC_CLK, SLEEP_STATIC,
      SLEEP_DEEPEST_STOP, DEBUG_HALT, ON_CHIP_DEBUG_RUN, CTRL_WRITE,
      CTRL_ENABLE, CTRL_PRESCALER_CLEAR, CTRL_DIRECT_WAKE_ENABLE,
      CTRL_CRYSTAL_OSC_SELECT, TOP_WRITE, COUNT_WRITE, IRQ_ENABLE_SET,
      IRQ_ENABLE_CLEAR, IRQ_STATUS_CLEAR, ENABLE_VIEW, PRESCALER_CLEAR_VIEW,
      DIRECT_WAKE_ENABLE_VIEW, CRYSTAL_OSC_SELECT_VIEW, BUSY, IRQ_MASK_VIEW,
      IRQ_STATUS_VIEW, IRQ_REQUEST, IRQ_WAKE, DIRECT_WAKE;
   logic [PSEL_W-1:0] CTRL_PSEL, PSEL_VIEW;
   logic [CNT_W-1:0]  TOP_WDATA, COUNT_WDATA, TOP_VIEW, COUNT_VALUE;
   int                err_total, samples_checked, cyc, t0, t1;

   rtc_core i_dut (.*);

   initial begin
      CLK_SYS = 0;
      forever #20 CLK_SYS = ~CLK_SYS;
   end
   // -------------------------------------------
   // oscillators: rc 4 cycles, crystal 6 cycles
   // -------------------------------------------
   always @(negedge CLK_SYS) begin
      cyc          <= cyc + 1;
      RC_OSC_CLK   <= cyc[1];
      // crystal runs from the start, before it is selected
      XTAL_OSC_CLK <= (cyc % 6) > 2;
      if (cyc == 5000) begin
         err_total++;
         close_out();
      end
   end
   // ----------------
   // shared tasks
   // ----------------
   task automatic check(input logic [CNT_W-1:0] seen, exp, input string m);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s got %h want %h", $time, m,
                  seen, exp);
      end
   endtask : check
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out
   task automatic settle();
      check(BUSY, 1, "busy after write");
      repeat (100) if (BUSY === 1'b1) @(negedge CLK_SYS);
      check(BUSY, 0, "busy stuck");
      @(negedge CLK_SYS);
   endtask : settle
   // d[7:4] tap, d3 crystal, d2 wake, d1 clear, d0 enable
   task automatic wr(input int k, input logic [CNT_W-1:0] d);
      {CTRL_PSEL, CTRL_CRYSTAL_OSC_SELECT, CTRL_DIRECT_WAKE_ENABLE,
       CTRL_PRESCALER_CLEAR, CTRL_ENABLE} = d[7:0];
      TOP_WDATA = d;
      COUNT_WDATA = d;
      CTRL_WRITE = (k == 0);
      TOP_WRITE = (k == 1);
      COUNT_WRITE = (k == 2);
      @(negedge CLK_SYS);
      {CTRL_WRITE, TOP_WRITE, COUNT_WRITE} = 3'h0;
      settle();
   endtask : wr
   task automatic clr_flag();
      IRQ_STATUS_CLEAR = 1;
      @(negedge CLK_SYS);
      IRQ_STATUS_CLEAR = 0;
   endtask : clr_flag
   task automatic flag_wait();
      repeat (400) if (IRQ_STATUS_VIEW !== 1'b1) @(negedge CLK_SYS);
   endtask : flag_wait
   task automatic wrap_wait(output int t);
      flag_wait();
      t = cyc;
      clr_flag();
   endtask : wrap_wait
   // ----------------
   // scenarios
   // ----------------
   task automatic t_load_drop();
      wr(2, 32'h5);
      check(COUNT_VALUE, 32'h5, "count load");
      wr(2, 32'h0);
      TOP_WDATA = 32'h3;
      TOP_WRITE = 1;
      @(negedge CLK_SYS);
      TOP_WRITE = 0;
      COUNT_WRITE = 1;
      COUNT_WDATA = 32'h9;
      @(negedge CLK_SYS);
      COUNT_WRITE = 0;
      repeat (100) if (BUSY === 1'b1) @(negedge CLK_SYS);
      repeat (2) @(negedge CLK_SYS);
      check(TOP_VIEW, 32'h3, "top load");
      check(COUNT_VALUE, 32'h0, "busy write kept out");
      $display("load and drop done");
   endtask : t_load_drop
   task automatic t_period();
      for (int i = 0; i < 2; i++) begin
         wr(0, (i << 4) | (i << 3) | 1);
         check(CRYSTAL_OSC_SELECT_VIEW, i, "oscillator select");
         check(PSEL_VIEW, i, "tap select");
         check(ENABLE_VIEW, 1, "enable view");
         wrap_wait(t0);
         wrap_wait(t0);
         wrap_wait(t1);
         check(t1 - t0, 4 * (2 << i) * (i ? 6 : 4),
               "wrap period");
      end
      $display("period done");
   endtask : t_period
   task automatic t_irq();
      IRQ_ENABLE_SET = 1;
      @(negedge CLK_SYS);
      IRQ_ENABLE_SET = 0;
      check(IRQ_MASK_VIEW, 1, "mask set");
      flag_wait();
      @(negedge CLK_SYS);
      check(IRQ_REQUEST, 1, "request");
      check(IRQ_WAKE, 1, "interrupt wake");
      SLEEP_DEEPEST_STOP = 1;
      @(negedge CLK_SYS);
      check(IRQ_REQUEST, 0, "deepest stop request");
      check(IRQ_WAKE, 0, "deepest stop wake");
      SLEEP_DEEPEST_STOP = 0;
      SLEEP_STATIC = 1;
      @(negedge CLK_SYS);
      check(IRQ_REQUEST, 1, "request in static");
      check(IRQ_WAKE, 0, "static interrupt wake");
      SLEEP_STATIC = 0;
      clr_flag();
      check({IRQ_STATUS_VIEW, IRQ_REQUEST}, 0, "status clear");
      IRQ_ENABLE_CLEAR = 1;
      @(negedge CLK_SYS);
      IRQ_ENABLE_CLEAR = 0;
      check(IRQ_MASK_VIEW, 0, "mask clear");
      $display("interrupt done");
   endtask : t_irq
   task automatic t_wake();
      wr(0, 32'h1f);
      check(PRESCALER_CLEAR_VIEW, 0, "clear bit reads zero");
      check(DIRECT_WAKE_ENABLE_VIEW, 1, "wake enable set");
      wrap_wait(t0);
      flag_wait();
      repeat (2) @(negedge CLK_SYS);
      check(DIRECT_WAKE, 1, "direct wake");
      check(IRQ_REQUEST, 0, "wake without mask");
      SLEEP_STATIC = 1;
      @(negedge CLK_SYS);
      check(DIRECT_WAKE, 0, "static wake");
      SLEEP_STATIC = 0;
      clr_flag();
      check(DIRECT_WAKE, 1, "wake held after flag clear");
      wr(0, 32'h19);
      check(DIRECT_WAKE_ENABLE_VIEW, 0, "wake enable cleared");
      check(DIRECT_WAKE, 0, "wake released");
      $display("wake done");
   endtask : t_wake
   task automatic t_halt();
      DEBUG_HALT = 1;
      repeat (10) @(negedge CLK_SYS);
      clr_flag();
      repeat (200) @(negedge CLK_SYS);
      check(IRQ_STATUS_VIEW, 0, "frozen in halt");
      ON_CHIP_DEBUG_RUN = 1;
      repeat (200) @(negedge CLK_SYS);
      check(IRQ_STATUS_VIEW, 1, "kept running");
      $display("halt done");
   endtask : t_halt

   initial begin
      {SLEEP_STATIC, SLEEP_DEEPEST_STOP, DEBUG_HALT, ON_CHIP_DEBUG_RUN,
       IRQ_ENABLE_SET, IRQ_ENABLE_CLEAR, IRQ_STATUS_CLEAR, CTRL_WRITE,
       TOP_WRITE, COUNT_WRITE, CTRL_ENABLE,
       CTRL_PRESCALER_CLEAR, CTRL_DIRECT_WAKE_ENABLE, CTRL_CRYSTAL_OSC_SELECT,
       CTRL_PSEL, TOP_WDATA, COUNT_WDATA} = '0;
      RESET = 1;
      repeat (5) @(posedge CLK_SYS);
      @(negedge CLK_SYS);
      RESET = 0;
      check(TOP_VIEW, TOP_RESET, "top reset");
      check(COUNT_VALUE, CNT_RESET, "count reset");
      check({BUSY, IRQ_MASK_VIEW, ENABLE_VIEW, IRQ_STATUS_VIEW},
            0, "reset");
      t_load_drop();
      t_period();
      t_irq();
      t_wake();
      t_halt();
      wr(0, 32'h0);
      check(ENABLE_VIEW, 0, "counter stopped");
      close_out();
   end
endmodule : real_time_counter_test
`default_nettype wire
